// ==== pkg/pbm_pkg.sv ====
// constants shared by the port-B alternate function mux
package pbm_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned PIN_DI_SDA = 0;
  localparam int unsigned PIN_DO = 1;
  localparam int unsigned PIN_SERIAL_BLOCK_CLOCK_IN_SCL = 2;
  localparam int unsigned PIN_OSC_ONE = 4;
  localparam int unsigned PIN_OSC_TWO = 5;
  localparam int unsigned PIN_IRQ_ZERO = 6;
  localparam int unsigned PIN_RESET = 7;
  localparam int unsigned PIN_CHANGE_BASE = 8;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] CH_B_PINS = 8'hAA;
  localparam logic [7:0] OSC_ONE_MASK = 8'h10;
  localparam logic [7:0] RESET_MASK = 8'h80;
  localparam logic [7:0] OSC_TWO_MASK = 8'h20;
  localparam logic [7:0] SYNC_RST = 8'hFF;
  typedef enum logic [1:0] {
    PBM_B7_GPIO = 2'b00,
    PBM_B7_RESET = 2'b01,
    PBM_B7_DEBUG = 2'b10
  } pbm_b7_role_t;
  localparam pbm_b7_role_t B7_ROLE_RST = PBM_B7_RESET;
endpackage

// ==== src/pbm_sync3.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pbm_sync3 (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [pbm_pkg::PORT_W-1:0] async_i,
  output logic [pbm_pkg::PORT_W-1:0] sync_o
);
  import pbm_pkg::*;
  logic [PORT_W-1:0] s1_q;
  logic [PORT_W-1:0] s2_q;
  logic [PORT_W-1:0] s3_q;
  logic [PORT_W-1:0] held_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit only moves once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_q <= SYNC_RST;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          held_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign sync_o = held_q;
endmodule

// ==== src/pbm_pin_cell.sv ====
// one pin's override combiner: direction, value and pull-up
`timescale 1ns/1ns
module pbm_pin_cell (
  input wire logic dir_i,
  input wire logic out_i,
  input wire logic pud_i,
  input wire logic ddoe_i,
  input wire logic ddov_i,
  input wire logic pvoe_i,
  input wire logic pvov_i,
  input wire logic puoe_i,
  input wire logic puov_i,
  output logic oe_o,
  output logic val_o,
  output logic pu_o
);
  import pbm_pkg::*;
  logic oe;

  assign oe = ddoe_i ? ddov_i : dir_i;
  assign oe_o = oe;
  assign val_o = pvoe_i ? pvov_i : out_i;
  // latch bit enables pull-up only while the pin is an input
  assign pu_o = puoe_i ? puov_i : (~oe & out_i & ~pud_i);
endmodule

// ==== src/pbm_port_b_mux.sv ====
// port-B alternate function pin mux with registered pad controls
`timescale 1ns/1ns
module pbm_port_b_mux (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ordinary port state from the port registers
  input wire logic [pbm_pkg::PORT_W-1:0] portb_dir_i,
  input wire logic [pbm_pkg::PORT_W-1:0] portb_out_i,
  input wire logic pullup_disable_i,
  input wire logic device_in_reset_i,
  // fuses and lock, high means programmed
  input wire logic reset_pin_disable_fuse_i,
  input wire logic debug_link_enable_fuse_i,
  input wire logic lock_bits_programmed_i,
  input wire logic clock_output_fuse_i,
  // clock source selection
  input wire logic oscillator_pin_one_used_i,
  input wire logic oscillator_pin_two_used_i,
  input wire logic divided_clock_i,
  // timer 1
  input wire logic timer1_cmp_a_en_i,
  input wire logic timer1_cmp_a_i,
  input wire logic timer1_cmp_b_en_i,
  input wire logic timer1_cmp_b_i,
  input wire logic [pbm_pkg::PORT_W-1:0] timer1_pin_select_reg_i,
  // serial block
  input wire logic serial_two_wire_i,
  input wire logic serial_three_wire_i,
  input wire logic serial_default_pos_i,
  input wire logic serial_shift_out_i,
  input wire logic serial_scl_hold_i,
  // debug link transmit: high pulls the line low
  input wire logic one_wire_debug_drive_low_i,
  // pads
  input wire logic [pbm_pkg::PORT_W-1:0] pad_i,
  output logic [pbm_pkg::PORT_W-1:0] pad_o,
  output logic [pbm_pkg::PORT_W-1:0] pad_oe_o,
  output logic [pbm_pkg::PORT_W-1:0] pad_pullup_o,
  // read-back and alternate inputs
  output logic [pbm_pkg::PORT_W-1:0] portb_dir_rd_o,
  output logic [pbm_pkg::PORT_W-1:0] portb_out_rd_o,
  output logic [pbm_pkg::PORT_W-1:0] portb_in_rd_o,
  output logic [pbm_pkg::PORT_W-1:0] pin_change_src_o,
  output logic external_irq_zero_o,
  output logic serial_block_clock_in_o,
  output logic serial_data_in_o,
  output logic pin_reset_req_o,
  output logic one_wire_debug_io_o,
  output logic debug_mode_o
);
  import pbm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pad input synchronisation

  logic [PORT_W-1:0] pin_sync;

  pbm_sync3 u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pad_i),
    .sync_o(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin roles

  pbm_b7_role_t b7_role;
  logic osc_one_pin;
  logic osc_two_pin;
  logic clk_out_pin;
  logic usi_two_wire;
  logic usi_three_wire;

  always_comb begin
    if (debug_link_enable_fuse_i && !lock_bits_programmed_i) begin
      b7_role = PBM_B7_DEBUG;
    end else if (!reset_pin_disable_fuse_i) begin
      b7_role = PBM_B7_RESET;
    end else begin
      b7_role = PBM_B7_GPIO;
    end
  end

  assign osc_one_pin = oscillator_pin_one_used_i;
  assign osc_two_pin = oscillator_pin_two_used_i;
  // crystal use of bit 5 wins over the clock output
  assign clk_out_pin = clock_output_fuse_i & ~osc_two_pin;
  assign usi_two_wire = serial_two_wire_i & serial_default_pos_i;
  assign usi_three_wire = serial_three_wire_i & serial_default_pos_i;

  ////////////////////////////////////////////////////////////////////////////
  // override vectors

  logic [PORT_W-1:0] ddoe;
  logic [PORT_W-1:0] ddov;
  logic [PORT_W-1:0] pvoe;
  logic [PORT_W-1:0] pvov;
  logic [PORT_W-1:0] puoe;
  logic [PORT_W-1:0] puov;
  logic [PORT_W-1:0] tmr_en;
  logic [PORT_W-1:0] tmr_val;

  // even pins carry channel A, odd pins channel B
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (CH_B_PINS[i]) begin
        tmr_en[i] = timer1_cmp_b_en_i & timer1_pin_select_reg_i[i];
        tmr_val[i] = timer1_cmp_b_i;
      end else begin
        tmr_en[i] = timer1_cmp_a_en_i & timer1_pin_select_reg_i[i];
        tmr_val[i] = timer1_cmp_a_i;
      end
    end
  end

  always_comb begin
    // timer drives the value only; direction stays with the port bit
    ddoe = PORT_RST;
    ddov = PORT_RST;
    pvoe = tmr_en;
    pvov = tmr_val;
    puoe = PORT_RST;
    puov = PORT_RST;

    // bit 0: two-wire SDA is open drain, three-wire input left alone
    if (usi_two_wire) begin
      ddoe[PIN_DI_SDA] = 1'b1;
      ddov[PIN_DI_SDA] = (serial_shift_out_i | portb_out_i[PIN_DI_SDA])
        & portb_dir_i[PIN_DI_SDA];
      if (portb_dir_i[PIN_DI_SDA]) begin
        pvoe[PIN_DI_SDA] = 1'b1;
        pvov[PIN_DI_SDA] = 1'b0;
      end
    end

    // bit 1: data out replaces the latch, direction still software's
    if (usi_three_wire) begin
      pvoe[PIN_DO] = 1'b1;
      pvov[PIN_DO] = serial_shift_out_i;
    end

    // bit 2: SCL held low by the serial block when it stretches
    if (usi_two_wire) begin
      ddoe[PIN_SERIAL_BLOCK_CLOCK_IN_SCL] = 1'b1;
      ddov[PIN_SERIAL_BLOCK_CLOCK_IN_SCL] = (serial_scl_hold_i | portb_out_i[PIN_SERIAL_BLOCK_CLOCK_IN_SCL])
        & portb_dir_i[PIN_SERIAL_BLOCK_CLOCK_IN_SCL];
      if (portb_dir_i[PIN_SERIAL_BLOCK_CLOCK_IN_SCL]) begin
        pvoe[PIN_SERIAL_BLOCK_CLOCK_IN_SCL] = 1'b1;
        pvov[PIN_SERIAL_BLOCK_CLOCK_IN_SCL] = 1'b0;
      end
    end

    // bit 4: clock pin is analog, no drive and no pull-up
    if (osc_one_pin) begin
      ddoe[PIN_OSC_ONE] = 1'b1;
      ddov[PIN_OSC_ONE] = 1'b0;
      pvoe[PIN_OSC_ONE] = 1'b1;
      pvov[PIN_OSC_ONE] = 1'b0;
      puoe[PIN_OSC_ONE] = 1'b1;
      puov[PIN_OSC_ONE] = 1'b0;
    end

    // bit 5: crystal first, then clock output
    if (osc_two_pin) begin
      ddoe[PIN_OSC_TWO] = 1'b1;
      ddov[PIN_OSC_TWO] = 1'b0;
      pvoe[PIN_OSC_TWO] = 1'b1;
      pvov[PIN_OSC_TWO] = 1'b0;
      puoe[PIN_OSC_TWO] = 1'b1;
      puov[PIN_OSC_TWO] = 1'b0;
    end else if (clk_out_pin) begin
      ddoe[PIN_OSC_TWO] = 1'b1;
      ddov[PIN_OSC_TWO] = 1'b1;
      pvoe[PIN_OSC_TWO] = 1'b1;
      pvov[PIN_OSC_TWO] = divided_clock_i;
      puoe[PIN_OSC_TWO] = 1'b1;
      puov[PIN_OSC_TWO] = 1'b0;
    end

    // bit 7: reset input keeps its pull-up, debug line is open drain
    case (b7_role)
      PBM_B7_RESET: begin
        ddoe[PIN_RESET] = 1'b1;
        ddov[PIN_RESET] = 1'b0;
        pvoe[PIN_RESET] = 1'b1;
        pvov[PIN_RESET] = 1'b0;
        puoe[PIN_RESET] = 1'b1;
        puov[PIN_RESET] = 1'b1;
      end
      PBM_B7_DEBUG: begin
        ddoe[PIN_RESET] = 1'b1;
        ddov[PIN_RESET] = one_wire_debug_drive_low_i;
        pvoe[PIN_RESET] = 1'b1;
        pvov[PIN_RESET] = 1'b0;
        puoe[PIN_RESET] = 1'b1;
        puov[PIN_RESET] = 1'b1;
      end
      default: begin
      end
    endcase

    // device reset: release everything but the clock output and bit 7 in its reset or debug role
    if (device_in_reset_i) begin
      for (int i = 0; i < PORT_W; i++) begin
        if (!(i == PIN_OSC_TWO && clk_out_pin) && !(i == PIN_RESET
            && b7_role != PBM_B7_GPIO)) begin
          ddoe[i] = 1'b1;
          ddov[i] = 1'b0;
          pvoe[i] = 1'b1;
          pvov[i] = 1'b0;
          puoe[i] = 1'b1;
          puov[i] = 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin combiners

  logic [PORT_W-1:0] pin_oe;
  logic [PORT_W-1:0] pin_val;
  logic [PORT_W-1:0] pin_pu;

  for (genvar g = 0; g < PORT_W; g++) begin : g_pin
    pbm_pin_cell u_cell (
      .dir_i(portb_dir_i[g]),
      .out_i(portb_out_i[g]),
      .pud_i(pullup_disable_i),
      .ddoe_i(ddoe[g]),
      .ddov_i(ddov[g]),
      .pvoe_i(pvoe[g]),
      .pvov_i(pvov[g]),
      .puoe_i(puoe[g]),
      .puov_i(puov[g]),
      .oe_o(pin_oe[g]),
      .val_o(pin_val[g]),
      .pu_o(pin_pu[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-back masking

  logic [PORT_W-1:0] rd_mask;

  always_comb begin
    rd_mask = ~PORT_RST;
    if (b7_role == PBM_B7_RESET) begin
      rd_mask = rd_mask & ~RESET_MASK;
    end
    if (osc_one_pin) begin
      rd_mask = rd_mask & ~OSC_ONE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad registers

  logic [PORT_W-1:0] pad_q;
  logic [PORT_W-1:0] pad_oe_q;
  logic [PORT_W-1:0] pad_pu_q;

  // only power-on reset clears these; device reset keeps bit 5 clocking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_q <= PORT_RST;
      pad_oe_q <= PORT_RST;
      pad_pu_q <= PORT_RST;
    end else begin
      pad_q <= pin_val;
      pad_oe_q <= pin_oe;
      pad_pu_q <= pin_pu;
    end
  end

  assign pad_o = pad_q;
  assign pad_oe_o = pad_oe_q;
  assign pad_pullup_o = pad_pu_q;

  ////////////////////////////////////////////////////////////////////////////
  // read-back registers

  logic [PORT_W-1:0] dir_rd_q;
  logic [PORT_W-1:0] out_rd_q;
  logic [PORT_W-1:0] in_rd_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_rd_q <= PORT_RST;
      out_rd_q <= PORT_RST;
      in_rd_q <= PORT_RST;
    end else begin
      dir_rd_q <= portb_dir_i & rd_mask;
      out_rd_q <= portb_out_i & rd_mask;
      in_rd_q <= pin_sync & rd_mask;
    end
  end

  assign portb_dir_rd_o = dir_rd_q;
  assign portb_out_rd_o = out_rd_q;
  assign portb_in_rd_o = in_rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // alternate inputs

  logic [PORT_W-1:0] pcsrc_q;
  logic irq0_q;
  logic sclk_q;
  logic sdi_q;

  // inputs are never overridden, so data in needs software to set input
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcsrc_q <= SYNC_RST;
      irq0_q <= 1'b1;
      sclk_q <= 1'b1;
      sdi_q <= 1'b1;
    end else begin
      pcsrc_q <= pin_sync;
      irq0_q <= pin_sync[PIN_IRQ_ZERO];
      sclk_q <= pin_sync[PIN_SERIAL_BLOCK_CLOCK_IN_SCL];
      sdi_q <= pin_sync[PIN_DI_SDA];
    end
  end

  assign pin_change_src_o = pcsrc_q;
  assign external_irq_zero_o = irq0_q;
  assign serial_block_clock_in_o = sclk_q;
  assign serial_data_in_o = sdi_q;

  ////////////////////////////////////////////////////////////////////////////
  // reset and debug line

  logic dbg_mode_q;
  logic rst_req_q;
  logic dbg_rx_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_mode_q <= 1'b0;
      rst_req_q <= 1'b0;
      dbg_rx_q <= 1'b1;
    end else begin
      dbg_mode_q <= (b7_role == PBM_B7_DEBUG);
      rst_req_q <= (b7_role == PBM_B7_RESET) & ~pin_sync[PIN_RESET];
      dbg_rx_q <= (b7_role == PBM_B7_DEBUG) ? pin_sync[PIN_RESET] : 1'b1;
    end
  end

  assign pin_reset_req_o = rst_req_q;
  assign one_wire_debug_io_o = dbg_rx_q;
  assign debug_mode_o = dbg_mode_q;
endmodule

// ==== dv/pbm_port_b_mux_asserts.sv ====
// concurrent checks on the port-B mux ports
`timescale 1ns/1ns
module pbm_port_b_mux_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] portb_dir_i,
  input wire logic [7:0] portb_out_i,
  input wire logic pullup_disable_i,
  input wire logic device_in_reset_i,
  input wire logic reset_pin_disable_fuse_i,
  input wire logic debug_link_enable_fuse_i,
  input wire logic lock_bits_programmed_i,
  input wire logic clock_output_fuse_i,
  input wire logic oscillator_pin_one_used_i,
  input wire logic oscillator_pin_two_used_i,
  input wire logic divided_clock_i,
  input wire logic timer1_cmp_b_en_i,
  input wire logic timer1_cmp_b_i,
  input wire logic [7:0] timer1_pin_select_reg_i,
  input wire logic serial_two_wire_i,
  input wire logic serial_three_wire_i,
  input wire logic serial_default_pos_i,
  input wire logic serial_shift_out_i,
  input wire logic one_wire_debug_drive_low_i,
  input wire logic [7:0] pad_i,
  input wire logic [7:0] pad_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_pullup_o,
  input wire logic [7:0] portb_dir_rd_o,
  input wire logic [7:0] portb_out_rd_o,
  input wire logic [7:0] portb_in_rd_o,
  input wire logic [7:0] pin_change_src_o,
  input wire logic external_irq_zero_o,
  input wire logic serial_block_clock_in_o,
  input wire logic serial_data_in_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dbg, rst7, do3;
  assign dbg = debug_link_enable_fuse_i & ~lock_bits_programmed_i;
  assign rst7 = ~reset_pin_disable_fuse_i & ~dbg;
  assign do3 = serial_three_wire_i & ~serial_two_wire_i & serial_default_pos_i;
  ////////////////////////////////////////////////////////////////
  // pads must sit still long enough to clear sync and filter
  sequence pads_steady;
    $stable(pad_i)[*7];
  endsequence
  sequence live_cfg;
    $past(rst_n_i) && !$past(device_in_reset_i);
  endsequence
  gpio_dir_a: assert property (live_cfg |-> pad_oe_o[3] == $past(portb_dir_i[3]))
    else $error("pin 3 drive does not follow direction");
  timer_pwm_a: assert property (live_cfg ##0 $past(timer1_pin_select_reg_i[3] &&
    timer1_cmp_b_en_i) |-> pad_o[3] == $past(timer1_cmp_b_i))
    else $error("pin 3 does not carry timer waveform");
  clk_out_a: assert property ($past(rst_n_i && clock_output_fuse_i &&
    !oscillator_pin_two_used_i) |-> pad_oe_o[5] && pad_o[5] == $past(divided_clock_i))
    else $error("divided clock missing on pin 5");
  xtal_two_a: assert property ($past(rst_n_i && oscillator_pin_two_used_i) |-> !pad_oe_o[5])
    else $error("crystal pin 5 driven");
  osc_one_a: assert property ($past(rst_n_i && oscillator_pin_one_used_i) |->
    !pad_oe_o[4] && !pad_pullup_o[4])
    else $error("clock pin 4 used as port");
  osc_read_a: assert property ($past(rst_n_i && oscillator_pin_one_used_i) |->
    {portb_dir_rd_o[4], portb_out_rd_o[4], portb_in_rd_o[4]} == 3'h0)
    else $error("clock pin 4 reads nonzero");
  reset_read_a: assert property ($past(rst_n_i && rst7, 2) && $past(rst_n_i && rst7) |->
    {portb_dir_rd_o[7], portb_out_rd_o[7], portb_in_rd_o[7], pad_oe_o[7]} == 4'h0)
    else $error("reset pin 7 acts as port");
  debug_line_a: assert property ($past(rst_n_i && dbg, 2) && $past(rst_n_i && dbg) |->
    !pad_o[7] && pad_pullup_o[7] && pad_oe_o[7] == $past(one_wire_debug_drive_low_i))
    else $error("debug line not open drain");
  do_out_a: assert property (live_cfg ##0 $past(do3 && !timer1_pin_select_reg_i[1]) |->
    pad_oe_o[1] == $past(portb_dir_i[1]) && (!pad_oe_o[1] || pad_o[1] == $past(serial_shift_out_i)))
    else $error("data out not on pin 1");
  do_pull_a: assert property (live_cfg ##0 $past(do3 && !portb_dir_i[1] && portb_out_i[1] &&
    !pullup_disable_i) |-> pad_pullup_o[1])
    else $error("pin 1 pull-up missing");
  pin_change_a: assert property (pads_steady |-> pin_change_src_o == pad_i)
    else $error("pin change sources wrong");
  alt_in_a: assert property (pads_steady |-> external_irq_zero_o == pad_i[6] &&
    serial_data_in_o == pad_i[0] && serial_block_clock_in_o == pad_i[2])
    else $error("alternate inputs wrong");
endmodule
bind pbm_port_b_mux pbm_port_b_mux_asserts pbm_port_b_mux_asserts_inst (.*);

// ==== dv/pbm_board_model.sv ====
// board circuitry on the port-B pads
`timescale 1ns/1ns
module pbm_board_model (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] lvl_o
);
  logic [7:0] flt_q;
  // an open wire swings every cycle so no stale level looks valid
  initial flt_q = 8'h5A;
  always @(posedge clk_i) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) begin
        lvl_o[i] = drv_i[i] & (ext_val_i[i] | ~ext_en_i[i]);
      end else if (ext_en_i[i]) begin
        lvl_o[i] = ext_val_i[i];
      end else begin
        lvl_o[i] = pu_i[i] | flt_q[i];
      end
    end
  end
endmodule

// ==== dv/pbm_port_b_mux_tb_top.sv ====
// testbench for the port-B alternate function mux
`timescale 1ns/1ns
module pbm_port_b_mux_tb_top;
  import pbm_pkg::*;
  logic clk_i = 1'h0;
  logic rst_n_i, pullup_disable_i, device_in_reset_i, reset_pin_disable_fuse_i;
  logic debug_link_enable_fuse_i, lock_bits_programmed_i, clock_output_fuse_i;
  logic oscillator_pin_one_used_i, oscillator_pin_two_used_i, divided_clock_i;
  logic timer1_cmp_a_en_i, timer1_cmp_a_i, timer1_cmp_b_en_i, timer1_cmp_b_i;
  logic serial_two_wire_i, serial_three_wire_i, serial_default_pos_i;
  logic serial_shift_out_i, serial_scl_hold_i, one_wire_debug_drive_low_i;
  logic [7:0] portb_dir_i, portb_out_i, timer1_pin_select_reg_i, pad_i, ext_en, ext_val;
  logic [7:0] pad_o, pad_oe_o, pad_pullup_o, portb_dir_rd_o, portb_out_rd_o;
  logic [7:0] portb_in_rd_o, pin_change_src_o, pat;
  logic external_irq_zero_o, serial_block_clock_in_o, serial_data_in_o;
  logic pin_reset_req_o, one_wire_debug_io_o, debug_mode_o;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  pbm_port_b_mux pbm_port_b_mux_inst (.*);
  pbm_board_model pbm_board_model_inst (.clk_i(clk_i), .drv_i(pad_o), .oe_i(pad_oe_o),
    .pu_i(pad_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pad_i));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic idle();
    {pullup_disable_i, device_in_reset_i, debug_link_enable_fuse_i} <= 3'h0;
    {lock_bits_programmed_i, clock_output_fuse_i, divided_clock_i} <= 3'h0;
    {oscillator_pin_one_used_i, oscillator_pin_two_used_i} <= 2'h0;
    {timer1_cmp_a_en_i, timer1_cmp_a_i, timer1_cmp_b_en_i, timer1_cmp_b_i} <= 4'h0;
    {serial_two_wire_i, serial_three_wire_i, serial_default_pos_i} <= 3'h0;
    {serial_shift_out_i, serial_scl_hold_i, one_wire_debug_drive_low_i} <= 3'h0;
    reset_pin_disable_fuse_i <= 1'h1;
    {portb_dir_i, portb_out_i, timer1_pin_select_reg_i, ext_en, ext_val} <= 40'h0;
  endtask
  // idle lands one edge before the case drives, never in the same step
  task automatic start_case();
    @(posedge clk_i);
    idle();
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_gpio();
    start_case();
    portb_dir_i <= 8'hA5;
    portb_out_i <= 8'h3C;
    settle(2);
    chk(pad_oe_o, 8'hA5);
    chk(pad_o & 8'hA5, 8'h24);
    chk(pad_pullup_o, 8'h18);
    chk(portb_dir_rd_o, 8'hA5);
    @(posedge clk_i);
    pullup_disable_i <= 1'h1;
    settle(2);
    chk(pad_pullup_o, 8'h00);
  endtask
  task automatic t_timer();
    start_case();
    portb_dir_i <= 8'h0F;
    timer1_pin_select_reg_i <= 8'hFF;
    {timer1_cmp_a_en_i, timer1_cmp_a_i, timer1_cmp_b_en_i, timer1_cmp_b_i} <= 4'hE;
    settle(2);
    chk(pad_oe_o, 8'h0F);
    chk(pad_o & 8'h0F, ~CH_B_PINS & 8'h0F);
    @(posedge clk_i);
    {timer1_cmp_a_i, timer1_cmp_b_i} <= 2'h1;
    settle(2);
    chk(pad_o & 8'h0F, CH_B_PINS & 8'h0F);
    @(posedge clk_i);
    timer1_pin_select_reg_i <= 8'h05;
    settle(2);
    chk(pad_o & 8'h0F, 8'h00);
  endtask
  task automatic t_reset_pin();
    start_case();
    reset_pin_disable_fuse_i <= 1'h0;
    {portb_dir_i, portb_out_i, ext_en, ext_val} <= 32'hFFFF8080;
    settle(8);
    chk({4'h0, portb_dir_rd_o[7], portb_out_rd_o[7], portb_in_rd_o[7], pad_oe_o[7]}, 8'h00);
    chk({7'h00, pin_reset_req_o}, 8'h00);
    @(posedge clk_i);
    ext_val <= 8'h00;
    settle(8);
    chk({7'h00, pin_reset_req_o}, 8'h01);
  endtask
  task automatic t_debug();
    start_case();
    {reset_pin_disable_fuse_i, debug_link_enable_fuse_i, one_wire_debug_drive_low_i} <= 3'h3;
    settle(3);
    chk({5'h00, pad_oe_o[7], pad_o[7], pad_pullup_o[7]}, 8'h05);
    settle(3);
    chk({6'h00, one_wire_debug_io_o, debug_mode_o}, 8'h01);
    @(posedge clk_i);
    one_wire_debug_drive_low_i <= 1'h0;
    settle(8);
    chk({6'h00, one_wire_debug_io_o, debug_mode_o}, 8'h03);
    @(posedge clk_i);
    lock_bits_programmed_i <= 1'h1;
    settle(3);
    chk({7'h00, debug_mode_o}, 8'h00);
  endtask
  task automatic t_clock();
    start_case();
    {clock_output_fuse_i, device_in_reset_i} <= 2'h3;
    {portb_dir_i, portb_out_i} <= 16'hDFDF;
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_i);
      divided_clock_i <= v[0];
      settle(2);
      chk({6'h00, pad_oe_o[5], pad_o[5]}, {6'h00, 1'h1, v[0]});
    end
    chk(pad_oe_o | pad_pullup_o, 8'h20);
    @(posedge clk_i);
    oscillator_pin_two_used_i <= 1'h1;
    settle(2);
    chk({7'h00, pad_oe_o[5]}, 8'h00);
  endtask
  task automatic t_osc();
    start_case();
    oscillator_pin_one_used_i <= 1'h1;
    {portb_dir_i, portb_out_i, ext_en, ext_val} <= 32'hFFFF1010;
    settle(8);
    chk({4'h0, pad_oe_o[4], portb_dir_rd_o[4], portb_out_rd_o[4], portb_in_rd_o[4]}, 8'h00);
  endtask
  task automatic t_serial();
    start_case();
    {serial_three_wire_i, serial_default_pos_i, serial_shift_out_i} <= 3'h7;
    {portb_dir_i, ext_en, ext_val} <= 24'h020504;
    settle(8);
    chk({5'h00, pad_oe_o[0], pad_oe_o[1], pad_o[1]}, 8'h03);
    chk({6'h00, serial_block_clock_in_o, serial_data_in_o}, 8'h02);
    @(posedge clk_i);
    {portb_dir_i, portb_out_i} <= 16'h0002;
    settle(2);
    chk({6'h00, pad_oe_o[1], pad_pullup_o[1]}, 8'h01);
    @(posedge clk_i);
    {serial_three_wire_i, serial_two_wire_i, serial_scl_hold_i} <= 3'h3;
    {portb_dir_i, portb_out_i} <= 16'h0500;
    settle(2);
    chk({4'h0, pad_oe_o[2], pad_o[2], pad_oe_o[0], pad_o[0]}, 8'h0A);
    @(posedge clk_i);
    {serial_shift_out_i, serial_scl_hold_i} <= 2'h0;
    settle(2);
    chk({4'h0, pad_oe_o[2], pad_o[2], pad_oe_o[0], pad_o[0]}, 8'h00);
  endtask
  task automatic t_inputs();
    start_case();
    ext_en <= 8'hFF;
    for (int i = 0; i < 2; i++) begin
      pat = i ? 8'hA5 : 8'h5A;
      @(posedge clk_i);
      ext_val <= pat;
      settle(8);
      chk(pin_change_src_o, pat);
      chk({7'h00, external_irq_zero_o}, {7'h00, pat[6]});
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  // whole run is about 130 cycles; this ceiling only catches hangs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    rst_n_i = 1'h0;
    idle();
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_gpio();
    t_timer();
    t_reset_pin();
    t_debug();
    t_clock();
    t_osc();
    t_serial();
    t_inputs();
    print_verdict();
  end
endmodule
